// File: hw/scan_host_pkg.sv
// Constants, register map and state codes of the scan master host port.
// Assumes one core clock; the host strobe arrives asynchronously to it.
// ===========================================================================
// Functional notes
// - Three address bits select eight registers
// - Eight-bit two-way bus, strobe-timed, asynchronous
// - Reads drive bus only while strobe low
// - Writes never drive the data bus
// - Address at strobe fall, data at rise
// - Ready low while blocked, then access completes
// - Incoming buffer read stalls while empty
// - Outgoing write stalls while full or clearing
// - Busy opcode stalls config, command, counter writes
// - Software reset write never stalls
// - Writes lead reads by five at most in full-duplex retimed commands
// - All readable; status, incoming buffer read-only
// - Pin control writes during command dropped; outgoing writes pass
// - Reserved read-only bits read zero
// - Stall causes other than the full-duplex lead limit visible in status and command
package scan_host_pkg;

  // ===========================================================================
  // Register offsets
  localparam logic [2:0] ADDR_MODE_CFG_A = 3'h0;
  localparam logic [2:0] ADDR_DIV_CFG_B = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_COMMAND = 3'h3;
  localparam logic [2:0] ADDR_OUTGOING = 3'h4;
  localparam logic [2:0] ADDR_INCOMING = 3'h5;
  localparam logic [2:0] ADDR_COUNTER = 3'h6;
  localparam logic [2:0] ADDR_PIN_CTL = 3'h7;

  // ===========================================================================
  // Reset values
  localparam logic [7:0] RST_MODE_CFG_A = 8'h00;
  localparam logic [7:0] RST_DIV_CFG_B = 8'h80;
  localparam logic [7:0] RST_COMMAND = 8'h00;
  localparam logic [7:0] RST_PIN_CTL = 8'h00;

  // ===========================================================================
  // Field positions
  localparam int SOFTWARE_RESET_BIT_BIT = 7;      // Software reset bit in command
  localparam int OPCODE_MSB = 3;     // Command opcode field top bit
  localparam int RETIME_MSB = 3;     // Retiming delay field top bit

  // ===========================================================================
  // Counts
  localparam int DATA_W = 8;         // Host bus width
  localparam int FIFO_DEPTH = 4;     // Scan buffer depth in words
  localparam logic [2:0] LEAD_LIMIT = 3'h5; // Max writes ahead of reads

  // Access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_GRANT = 3'b100
  } access_state_e;

endpackage

// File: hw/sync_bit.sv
// Two-flop synchroniser for one level into the core clock.
// Assumes the input may change at any time relative to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sync_bit #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Level in and out
  input wire logic asyncIn,
  output logic syncOut
);

  // ===========================================================================
  // Synchroniser stages
  logic meta_q;   // First stage, read only by second
  logic sync_q;   // Second stage

  // Two stages, constant reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;

endmodule
`default_nettype wire

// File: hw/host_fifo.sv
// Small synchronous FIFO for the scan data buffers.
// Assumes DEPTH is a power of two so pointers wrap naturally.
`timescale 1ns/1ps
`default_nettype none
module host_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Drop all contents
  input wire logic flush,
  // Fill side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // Drain side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = DEPTH[AW:0];

  // ===========================================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_q [DEPTH];   // Word storage
  logic [AW-1:0] wrPtr_q, wrPtr_d;   // Next slot to fill
  logic [AW-1:0] rdPtr_q, rdPtr_d;   // Oldest word
  logic [AW:0] count_q, count_d;     // Words held
  logic push, pop;

  // Honest full and empty
  assign inReady = count_q != FULL_COUNT;
  assign outValid = count_q != '0;
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Next pointers and count
  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (flush) begin
      wrPtr_d = '0;
      rdPtr_d = '0;
      count_d = '0;
    end else begin
      if (push) wrPtr_d = wrPtr_q + 1'b1;
      if (pop) rdPtr_d = rdPtr_q + 1'b1;
      if (push && !pop) count_d = count_q + 1'b1;
      else if (pop && !push) count_d = count_q - 1'b1;
    end
  end

  // Register state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Word storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push && !flush) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

endmodule
`default_nettype wire

// File: hw/scan_master_host_port.sv
// Host register port of the scan master: strobe decode, wait states,
// register file and the two scan data buffers.
// Assumes the scan engine outside drains/fills the buffers and reports
// command completion and sequencer state.
`timescale 1ns/1ps
`default_nettype none
module scan_master_host_port
  import scan_host_pkg::*;
(
  // Core clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host bus pins
  input wire logic accessStrobeN,
  input wire logic readNotWrite,
  input wire logic [2:0] hostAddr,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe,
  output logic hostReady,
  // Scan engine status
  input wire logic commandDone,
  input wire logic counterStateFlag,
  input wire logic [3:0] sequencerStateField,
  input wire logic outgoingClearing,
  input wire logic fullDuplexScan,
  input wire logic [7:0] counterReadData,
  // Outgoing scan data to engine
  output logic [7:0] scanOutData,
  output logic scanOutValid,
  input wire logic scanOutReady,
  // Incoming scan data from engine
  input wire logic [7:0] scanInData,
  input wire logic scanInValid,
  output logic scanInReady,
  // Register outputs to engine
  output logic [7:0] modeConfigA,
  output logic [7:0] dividerRetimeConfigB,
  output logic [7:0] commandControl,
  output logic [7:0] pinDirectControl,
  output logic softwareResetPulse,
  output logic counterWriteStrobe,
  output logic [7:0] counterWriteData
);

  // ===========================================================================
  // Strobe crossing
  logic strobeSyncN;   // Strobe level in core domain
  logic strobeLow;     // Synchronised strobe active

  sync_bit #(
    .RESET_VAL(1'b1)
  ) u_strobe_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .asyncIn(accessStrobeN),
    .syncOut(strobeSyncN)
  );
  assign strobeLow = !strobeSyncN;

  // ===========================================================================
  // Scan buffers
  logic outPush;          // Host write to outgoing buffer
  logic outInReady;       // Outgoing buffer not full
  logic inPop;            // Host read of incoming buffer
  logic inHasData;        // Incoming buffer not empty
  logic [7:0] inHeadData; // Oldest incoming word
  logic [7:0] wrData_q, wrData_d; // Last bus value under strobe

  // Outgoing buffer, cleared at scan start
  host_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_out_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(outgoingClearing || softwareResetPulse),
    .inData(wrData_q),
    .inValid(outPush),
    .inReady(outInReady),
    .outData(scanOutData),
    .outValid(scanOutValid),
    .outReady(scanOutReady)
  );

  // Incoming buffer, engine stalls when full
  host_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_in_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(softwareResetPulse),
    .inData(scanInData),
    .inValid(scanInValid),
    .inReady(scanInReady),
    .outData(inHeadData),
    .outValid(inHasData),
    .outReady(inPop)
  );

  // ===========================================================================
  // Access state
  access_state_e state_q, state_d;       // Access sequencer
  logic [2:0] addr_q, addr_d;            // Captured register index
  logic rd_q, rd_d;                      // Captured direction
  logic [7:0] readData_q, readData_d;    // Data presented on reads
  logic commit;                          // Access finished at strobe rise

  logic busy;          // Command opcode nonzero
  logic guarded;       // Register held off while busy
  logic limitActive;   // Lead limit applies
  logic [2:0] lead_q, lead_d;  // Writes ahead of reads
  logic blocked;       // Current access must wait
  logic [7:0] statusValue;
  logic [7:0] readMux;
  logic [7:0] outLast_q, outLast_d;   // Last outgoing word written

  assign busy = commandControl[OPCODE_MSB:0] != '0;
  assign limitActive = busy && fullDuplexScan && (dividerRetimeConfigB[RETIME_MSB:0] != '0);
  assign guarded = (addr_q == ADDR_MODE_CFG_A) || (addr_q == ADDR_DIV_CFG_B)
                || (addr_q == ADDR_COMMAND) || (addr_q == ADDR_COUNTER);

  assign statusValue = {!inHasData, !outInReady || outgoingClearing, counterStateFlag,
                        1'b0, sequencerStateField};

  // Block conditions for the captured access
  always_comb begin
    blocked = 1'b0;
    if (rd_q) begin
      blocked = (addr_q == ADDR_INCOMING) && !inHasData;
    end else if (addr_q == ADDR_OUTGOING) begin
      blocked = !outInReady || outgoingClearing || (limitActive && lead_q >= LEAD_LIMIT);
    end else begin
      blocked = busy && guarded && !(addr_q == ADDR_COMMAND && hostDataIn[SOFTWARE_RESET_BIT_BIT]);
    end
  end

  always_comb begin
    case (addr_q)
      ADDR_MODE_CFG_A: readMux = modeConfigA;
      ADDR_DIV_CFG_B: readMux = dividerRetimeConfigB;
      ADDR_STATUS: readMux = statusValue;
      ADDR_COMMAND: readMux = commandControl;
      ADDR_OUTGOING: readMux = outLast_q;
      ADDR_INCOMING: readMux = inHeadData;
      ADDR_COUNTER: readMux = counterReadData;
      ADDR_PIN_CTL: readMux = pinDirectControl;
      default: readMux = 8'h00;
    endcase
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    rd_d = rd_q;
    readData_d = readData_q;
    commit = 1'b0;
    wrData_d = accessStrobeN ? wrData_q : hostDataIn;
    case (state_q)
      ST_IDLE: begin
        if (strobeLow) begin
          addr_d = hostAddr;
          rd_d = readNotWrite;
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!strobeLow) begin
          state_d = ST_IDLE;
        end else if (!blocked) begin
          state_d = ST_GRANT;
          readData_d = readMux;
        end
      end
      ST_GRANT: begin
        // Finish at strobe rise
        if (!strobeLow) begin
          state_d = ST_IDLE;
          commit = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Register sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      addr_q <= '0;
      rd_q <= 1'b0;
      wrData_q <= '0;
      readData_q <= '0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      wrData_q <= wrData_d;
      readData_q <= readData_d;
    end
  end

  // ===========================================================================
  // Register file
  logic [7:0] cfgA_q, cfgA_d;
  logic [7:0] cfgB_q, cfgB_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] pinCtl_q, pinCtl_d;
  logic swReset_q, swReset_d;
  logic ctrWr_q, ctrWr_d;
  logic [7:0] ctrData_q, ctrData_d;
  logic wrCommit;

  assign wrCommit = commit && !rd_q;
  assign outPush = wrCommit && (addr_q == ADDR_OUTGOING);
  assign inPop = commit && rd_q && (addr_q == ADDR_INCOMING);

  // Register writes and lead count
  always_comb begin
    cfgA_d = cfgA_q;
    cfgB_d = cfgB_q;
    cmd_d = cmd_q;
    pinCtl_d = pinCtl_q;
    outLast_d = outLast_q;
    swReset_d = 1'b0;
    ctrWr_d = 1'b0;
    ctrData_d = ctrData_q;
    // Engine ends command
    if (commandDone) cmd_d[OPCODE_MSB:0] = '0;
    if (wrCommit) begin
      case (addr_q)
        ADDR_MODE_CFG_A: cfgA_d = wrData_q;
        ADDR_DIV_CFG_B: cfgB_d = wrData_q;
        ADDR_COMMAND: begin
          if (wrData_q[SOFTWARE_RESET_BIT_BIT]) begin
            cmd_d = {1'b0, wrData_q[6:4], 4'h0};
            swReset_d = 1'b1;
          end else begin
            cmd_d = wrData_q;
          end
        end
        ADDR_OUTGOING: outLast_d = wrData_q;
        ADDR_COUNTER: begin
          ctrWr_d = 1'b1;
          ctrData_d = wrData_q;
        end
        ADDR_PIN_CTL: if (!busy) pinCtl_d = wrData_q;
        default: cfgA_d = cfgA_q;
      endcase
    end
    lead_d = lead_q;
    if (!limitActive) begin
      lead_d = '0;
    end else if (outPush && !inPop) begin
      lead_d = lead_q + 3'h1;
    end else if (inPop && !outPush && lead_q != '0) begin
      lead_d = lead_q - 3'h1;
    end
  end

  // Register file flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfgA_q <= RST_MODE_CFG_A;
      cfgB_q <= RST_DIV_CFG_B;
      cmd_q <= RST_COMMAND;
      pinCtl_q <= RST_PIN_CTL;
      outLast_q <= '0;
      swReset_q <= 1'b0;
      ctrWr_q <= 1'b0;
      ctrData_q <= '0;
      lead_q <= '0;
    end else begin
      cfgA_q <= cfgA_d;
      cfgB_q <= cfgB_d;
      cmd_q <= cmd_d;
      pinCtl_q <= pinCtl_d;
      outLast_q <= outLast_d;
      swReset_q <= swReset_d;
      ctrWr_q <= ctrWr_d;
      ctrData_q <= ctrData_d;
      lead_q <= lead_d;
    end
  end

  // ===========================================================================
  // Outputs
  assign modeConfigA = cfgA_q;
  assign dividerRetimeConfigB = cfgB_q;
  assign commandControl = cmd_q;
  assign pinDirectControl = pinCtl_q;
  assign softwareResetPulse = swReset_q;
  assign counterWriteStrobe = ctrWr_q;
  assign counterWriteData = ctrData_q;
  assign hostDataOut = readData_q;
  assign hostDataOe = !accessStrobeN && readNotWrite;
  assign hostReady = accessStrobeN || (state_q == ST_GRANT);

  // ===========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_HIZ_IDLE: assert property (accessStrobeN |-> !hostDataOe)
    else $error("bus driven with strobe high");
  AST_HIZ_WRITE: assert property (!readNotWrite |-> !hostDataOe)
    else $error("bus driven during write");
  AST_EMPTY_STALL: assert property ((state_q == ST_WAIT && rd_q && addr_q == ADDR_INCOMING
    && !inHasData && strobeLow) |=> state_q != ST_GRANT)
    else $error("empty incoming read granted");
  AST_FULL_STALL: assert property ((state_q == ST_WAIT && !rd_q && addr_q == ADDR_OUTGOING
    && !outInReady) |=> state_q != ST_GRANT)
    else $error("full outgoing write granted");
  AST_BUSY_STALL: assert property ((state_q == ST_WAIT && !rd_q && busy && addr_q == ADDR_DIV_CFG_B)
    |=> state_q != ST_GRANT)
    else $error("config write granted while busy");
  AST_RESET_PASS: assert property ((state_q == ST_WAIT && strobeLow && !rd_q && addr_q == ADDR_COMMAND
    && hostDataIn[SOFTWARE_RESET_BIT_BIT]) |=> state_q == ST_GRANT)
    else $error("software reset write stalled");
  AST_LEAD_CAP: assert property (lead_q <= LEAD_LIMIT)
    else $error("outgoing lead beyond limit");
  AST_UNBLOCK: assert property ((state_q == ST_WAIT && strobeLow && !blocked)
    |=> state_q == ST_GRANT && hostReady)
    else $error("unblocked access not granted");
  AST_CFGA_WRITE: assert property ((wrCommit && addr_q == ADDR_MODE_CFG_A)
    |=> modeConfigA == $past(wrData_q))
    else $error("configuration write lost");
  AST_STATUS_RES: assert property ((state_q == ST_GRANT && rd_q && addr_q == ADDR_STATUS)
    |-> readData_q[4] == 1'b0)
    else $error("reserved status bit set");

  COV_READ_IN: cover property (inPop);
  COV_WRITE_OUT: cover property (outPush);
  COV_SW_RESET: cover property (softwareResetPulse);
  COV_STALL: cover property (state_q == ST_WAIT && blocked ##1 state_q == ST_GRANT);

endmodule
`default_nettype wire

// File: testbench/host_model.sv
// Host processor model: strobed byte accesses and the shared data bus.
// Assumes the device answers on hostReady; paced by clk_sys falling edges.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk_sys,
  // Host bus
  output logic accessStrobeN,
  output logic readNotWrite,
  output logic [2:0] hostAddr,
  output logic [7:0] busLevel,
  // Device answers
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe,
  input wire logic hostReady
);
  // ==========================================================================
  // Bus state
  logic hostDrive = 1'b0; // Host owns the bus
  logic [7:0] drvData = 8'h00; // Byte being written
  logic [7:0] floatPat = 8'h5a; // Level of an undriven bus

  initial begin
    accessStrobeN = 1'b1;
    readNotWrite = 1'b1;
    hostAddr = 3'h0;
  end

  assign busLevel = hostDataOe ? hostDataOut : (hostDrive ? drvData : floatPat);

  // Undriven bus flips every cycle
  always @(posedge clk_sys) floatPat <= ~busLevel;

  // ==========================================================================
  // hold direction and address
  task automatic access(input logic rw, input logic [2:0] a, input logic [7:0] wd, input int mw,
                        output logic [7:0] rdat, output int waited, output bit ok);
    ok = 1'b0;
    waited = 0;
    rdat = 8'h00;
    @(negedge clk_sys);
    readNotWrite = rw;
    hostAddr = a;
    drvData = wd;
    hostDrive = ~rw;
    accessStrobeN = 1'b0;
    // Wait for ready, or give up and drop
    while (!ok && waited < mw) begin
      @(negedge clk_sys);
      if (hostReady === 1'b1) begin
        ok = 1'b1;
        rdat = busLevel;
      end else begin
        waited++;
      end
    end
    repeat (2) @(negedge clk_sys);
    accessStrobeN = 1'b1;
    @(negedge clk_sys);
    hostDrive = 1'b0;
    // Strobe high long enough for the next access
    repeat (5) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench of the host port: register map, stalls, buffers.
// Assumes host_model as bus partner; bench plays the scan engine.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scan_host_pkg::*;
  // ==========================================================================
  // Pins and engine side
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic accessStrobeN, readNotWrite, hostDataOe, hostReady;
  logic [2:0] hostAddr, a;
  logic [7:0] hostDataIn, hostDataOut, scanOutData, modeConfigA, dividerRetimeConfigB;
  logic [7:0] commandControl, pinDirectControl, counterWriteData, rdat, d;
  logic commandDone = 1'b0, counterStateFlag = 1'b0, outgoingClearing = 1'b0, fullDuplexScan = 1'b0;
  logic [3:0] sequencerStateField = 4'h0;
  logic [7:0] counterReadData = 8'h00, scanInData = 8'h00;
  logic scanInValid = 1'b0, scanOutReady = 1'b0;
  logic scanOutValid, scanInReady, softwareResetPulse, counterWriteStrobe;
  // Bench bookkeeping
  int miscompares = 0;
  int comparisons = 0;
  int lastWait, swrCount = 0, ctrCount = 0;
  logic [7:0] outQ[$]; // Expected outgoing words
  logic [7:0] w[4]; // Incoming words
  logic [7:0] sh[8]; // Shadow of written registers
  bit g;

  always #2 clk_sys = ~clk_sys;

  scan_master_host_port u_dut (.clk_sys, .rst, .accessStrobeN, .readNotWrite, .hostAddr, .hostDataIn,
    .hostDataOut, .hostDataOe, .hostReady, .commandDone, .counterStateFlag, .sequencerStateField,
    .outgoingClearing, .fullDuplexScan, .counterReadData, .scanOutData, .scanOutValid, .scanOutReady,
    .scanInData, .scanInValid, .scanInReady, .modeConfigA, .dividerRetimeConfigB, .commandControl,
    .pinDirectControl, .softwareResetPulse, .counterWriteStrobe, .counterWriteData);
  host_model u_host (.clk_sys, .accessStrobeN, .readNotWrite, .hostAddr, .busLevel(hostDataIn),
    .hostDataOut, .hostDataOe, .hostReady);

  // ==========================================================================
  // Compare and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One host access, granted or dropped as expected
  task automatic xfer(input logic rw, input logic [2:0] ad, input logic [7:0] wd, input int mw, input bit expG);
    u_host.access(rw, ad, wd, mw, rdat, lastWait, g);
    check({7'h00, g}, {7'h00, expG});
    if (expG && !g) tally_and_finish();
  endtask
  task automatic rd(input logic [2:0] ad, input logic [7:0] e);
    xfer(1'b1, ad, 8'h00, 200, 1'b1);
    check(rdat, e);
  endtask
  // Engine pushes one incoming word
  task automatic push_in(input logic [7:0] v);
    int n;
    n = 0;
    @(negedge clk_sys);
    scanInData = v;
    scanInValid = 1'b1;
    while (scanInReady !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    scanInValid = 1'b0;
    scanInData = ~v;
    if (n == 50) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic done_pulse();
    @(negedge clk_sys);
    commandDone = 1'b1;
    @(negedge clk_sys);
    commandDone = 1'b0;
  endtask
  // Expected status byte
  function automatic logic [7:0] stat(input logic inEmpty, input logic outBlock);
    return {inEmpty, outBlock, counterStateFlag, 1'b0, sequencerStateField};
  endfunction
  // Writable bits, reserved ones kept zero
  function automatic logic [7:0] mask(input logic [2:0] ad);
    return (ad == ADDR_MODE_CFG_A) ? 8'h3f : (ad == ADDR_DIV_CFG_B) ? 8'hef : 8'h0f;
  endfunction

  // ==========================================================================
  // Bus and drain monitors
  always @(posedge clk_sys) begin
    check({7'h00, hostDataOe}, {7'h00, ~accessStrobeN & readNotWrite});
    if (accessStrobeN) check({7'h00, hostReady}, 8'h01);
    if (scanOutReady && scanOutValid === 1'b1 && outQ.size() > 0) check(scanOutData, outQ.pop_front());
    if (softwareResetPulse === 1'b1) swrCount++;
    if (counterWriteStrobe === 1'b1) ctrCount++;
  end

  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(33153));
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    counterStateFlag = 1'($urandom);
    sequencerStateField = 4'($urandom);
    counterReadData = 8'($urandom);
    // Reset values and decode
    rd(ADDR_MODE_CFG_A, RST_MODE_CFG_A);
    rd(ADDR_DIV_CFG_B, RST_DIV_CFG_B);
    rd(ADDR_COMMAND, RST_COMMAND);
    rd(ADDR_PIN_CTL, RST_PIN_CTL);
    rd(ADDR_COUNTER, counterReadData);
    rd(ADDR_STATUS, stat(1'b1, 1'b0));
    // Read-only places ignore writes
    xfer(1'b0, ADDR_STATUS, 8'hff, 50, 1'b1);
    xfer(1'b0, ADDR_INCOMING, 8'h3c, 50, 1'b1);
    rd(ADDR_STATUS, stat(1'b1, 1'b0));
    // Random writes and readback
    for (int i = 0; i < 9; i++) begin
      a = (i % 3 == 0) ? ADDR_MODE_CFG_A : (i % 3 == 1) ? ADDR_DIV_CFG_B : ADDR_PIN_CTL;
      d = 8'($urandom) & mask(a);
      sh[a] = d;
      xfer(1'b0, a, d, 50, 1'b1);
      rd(a, d);
    end
    check(modeConfigA, sh[0]);
    check(dividerRetimeConfigB, sh[1]);
    check(pinDirectControl, sh[7]);
    d = 8'($urandom);
    xfer(1'b0, ADDR_COUNTER, d, 50, 1'b1);
    check(counterWriteData, d);
    check(8'(ctrCount), 8'h01);
    // Empty incoming buffer stalls a read
    w[0] = 8'($urandom);
    fork
      rd(ADDR_INCOMING, w[0]);
      begin
        repeat (20) @(negedge clk_sys);
        push_in(w[0]);
      end
    join
    check({7'h00, lastWait >= 15}, 8'h01);
    // Fill incoming buffer until refused
    for (int i = 0; i < 4; i++) begin
      w[i] = 8'($urandom);
      push_in(w[i]);
    end
    check({7'h00, scanInReady}, 8'h00);
    rd(ADDR_STATUS, stat(1'b0, 1'b0));
    for (int i = 0; i < 4; i++) rd(ADDR_INCOMING, w[i]);
    rd(ADDR_STATUS, stat(1'b1, 1'b0));
    // Full outgoing buffer stalls a write
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      outQ.push_back(d);
      xfer(1'b0, ADDR_OUTGOING, d, 50, 1'b1);
    end
    rd(ADDR_OUTGOING, d);
    rd(ADDR_STATUS, stat(1'b1, 1'b1));
    outQ.push_back(8'ha5);
    fork
      xfer(1'b0, ADDR_OUTGOING, 8'ha5, 200, 1'b1);
      begin
        repeat (30) @(negedge clk_sys);
        scanOutReady = 1'b1;
      end
    join
    check({7'h00, lastWait >= 25}, 8'h01);
    // Clearing blocks the write; host gives up
    outgoingClearing = 1'b1;
    rd(ADDR_STATUS, stat(1'b1, 1'b1));
    xfer(1'b0, ADDR_OUTGOING, 8'h11, 30, 1'b0);
    outgoingClearing = 1'b0;
    // Running command holds off writes
    xfer(1'b0, ADDR_COMMAND, 8'h01, 50, 1'b1);
    check(commandControl, 8'h01);
    xfer(1'b0, ADDR_MODE_CFG_A, 8'h15, 30, 1'b0);
    xfer(1'b0, ADDR_COUNTER, 8'h22, 30, 1'b0);
    xfer(1'b0, ADDR_COMMAND, 8'h02, 30, 1'b0);
    xfer(1'b0, ADDR_PIN_CTL, ~sh[7] & 8'h0f, 50, 1'b1);
    check(pinDirectControl, sh[7]);
    check(modeConfigA, sh[0]);
    check(8'(ctrCount), 8'h01);
    d = 8'($urandom);
    outQ.push_back(d);
    xfer(1'b0, ADDR_OUTGOING, d, 50, 1'b1);
    xfer(1'b0, ADDR_COMMAND, 8'h80, 20, 1'b1);
    check(commandControl, 8'h00);
    check(8'(swrCount), 8'h01);
    // Completion releases a stalled write
    xfer(1'b0, ADDR_COMMAND, 8'h03, 50, 1'b1);
    fork
      xfer(1'b0, ADDR_DIV_CFG_B, 8'h83, 200, 1'b1);
      begin
        repeat (30) @(negedge clk_sys);
        done_pulse();
      end
    join
    check(dividerRetimeConfigB, 8'h83);
    check(commandControl, 8'h00);
    check({7'h00, lastWait >= 25}, 8'h01);
    // Full-duplex lead of five writes
    fullDuplexScan = 1'b1;
    xfer(1'b0, ADDR_COMMAND, 8'h01, 50, 1'b1);
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom);
      outQ.push_back(d);
      xfer(1'b0, ADDR_OUTGOING, d, 50, 1'b1);
    end
    xfer(1'b0, ADDR_OUTGOING, 8'h66, 40, 1'b0);
    push_in(8'h99);
    rd(ADDR_INCOMING, 8'h99);
    outQ.push_back(8'h77);
    xfer(1'b0, ADDR_OUTGOING, 8'h77, 50, 1'b1);
    done_pulse();
    fullDuplexScan = 1'b0;
    repeat (10) @(negedge clk_sys);
    check(8'(outQ.size()), 8'h00);
    // Second reset restores registers
    rst = 1'b1;
    @(negedge clk_sys) rst = 1'b0;
    check(modeConfigA, RST_MODE_CFG_A);
    check(dividerRetimeConfigB, RST_DIV_CFG_B);
    check(pinDirectControl, RST_PIN_CTL);
    rd(ADDR_STATUS, stat(1'b1, 1'b0));
    tally_and_finish();
  end
endmodule
`default_nettype wire
